// *** rtl/cmp_control.sv ***
// top of the dual comparator control block with its register port
// assumes a cpu master with one-cycle strobes and no wait states
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "cmp_params.svh"
// Function
// - output one when positive exceeds negative
// - enable bit switches comparator on
// - bit 4 picks positive pin a/b
// - bit 3 picks reference pin or internal
// - raw result drives pin when enabled and output enabled
// - bit 1 synced result, zero when disabled
// - hardware sets change flag on change
// - irq needs flag, channel and global enable
// - port0 input disable bits read zero
// - three select bits give eight configurations
// - two identical registers at ACh, ADh
module cmp_control
  import cmp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire reg_req_s req,
  output logic [7:0] rdata,
  // analog comparisons per channel: index {neg_sel, pos_sel}
  input wire logic [3:0] cmp_one_raw,
  input wire logic [3:0] cmp_two_raw,
  // port 0 pins, asynchronous
  input wire logic [7:0] port0_pins,
  // comparator output pins
  output logic compare_output_pin_one,
  output logic compare_output_pin_two,
  // interrupt requests
  output logic irq_one,
  output logic irq_two,
  // warm-up status, high while a channel is still settling
  output logic settling_one,
  output logic settling_two
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] comparator_one_control_q; // writable bits only
  logic [7:0] comparator_two_control_q;
  logic [7:0] irq_enable_reg0_q;
  logic [7:0] irq_enable_reg1_q;
  logic [7:0] port0_digital_input_disable_q;
  logic [7:0] p0_s1_q; // first synchroniser stage, port 0
  logic [7:0] p0_s2_q; // second stage
  chan_cfg_s cfg_one;
  chan_cfg_s cfg_two;
  logic clr_one; // write of zero to change flag, channel one
  logic clr_two;
  logic raw_one;
  logic raw_two;
  logic res_one;
  logic res_two;
  logic flag_one;
  logic flag_two;
  logic wr_one;
  logic wr_two;
  logic [7:0] rdata_d;
  logic [13:0] settle_one_q; // warm-up counters
  logic [13:0] settle_two_q;
  chan_state_e st_one_q;
  chan_state_e st_two_q;
  localparam logic [13:0] SETTLE = 14'(`SETTLE_CYCLES);

  assign wr_one = req.wr && req.addr == `CMP_ONE_ADDR;
  assign wr_two = req.wr && req.addr == `CMP_TWO_ADDR;

  // write of zero to bit 0 clears, one leaves the flag alone
  assign clr_one = wr_one && !req.wdata[`BIT_CHANGE];
  assign clr_two = wr_two && !req.wdata[`BIT_CHANGE];

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      comparator_one_control_q <= `REG_RESET;
      comparator_two_control_q <= `REG_RESET;
    end
    else
    begin
      // reserved, result and flag bits are not stored
      if (wr_one)
        comparator_one_control_q <= req.wdata & `CTRL_WMASK & 8'h3C;
      if (wr_two)
        comparator_two_control_q <= req.wdata & `CTRL_WMASK & 8'h3C;
    end
  end

  // interrupt enables and port 0 input disable
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_enable_reg0_q <= `REG_RESET;
      irq_enable_reg1_q <= `REG_RESET;
      port0_digital_input_disable_q <= `REG_RESET;
    end
    else if (req.wr)
    begin
      case (req.addr)
        `IRQ_EN0_ADDR: irq_enable_reg0_q <= req.wdata;
        `IRQ_EN1_ADDR: irq_enable_reg1_q <= req.wdata;
        `P0_DIS_ADDR: port0_digital_input_disable_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // configuration fields, same layout for both channels
  assign cfg_one = '{enable: comparator_one_control_q[`BIT_ENABLE],
                     pos_sel: comparator_one_control_q[`BIT_POS_SEL],
                     neg_sel: comparator_one_control_q[`BIT_NEG_SEL],
                     out_en: comparator_one_control_q[`BIT_OUT_EN]};
  assign cfg_two = '{enable: comparator_two_control_q[`BIT_ENABLE],
                     pos_sel: comparator_two_control_q[`BIT_POS_SEL],
                     neg_sel: comparator_two_control_q[`BIT_NEG_SEL],
                     out_en: comparator_two_control_q[`BIT_OUT_EN]};

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  cmp_channel u_one (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfg_one),
    .flag_clr(clr_one),
    .raw_cmp(cmp_one_raw),
    .raw_out(raw_one),
    .sync_res(res_one),
    .change_flag(flag_one)
  );

  cmp_channel u_two (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfg_two),
    .flag_clr(clr_two),
    .raw_cmp(cmp_two_raw),
    .raw_out(raw_two),
    .sync_res(res_two),
    .change_flag(flag_two)
  );

  // ------------------------------------------------------------
  // output pins
  // ------------------------------------------------------------
  // one flop here keeps the top-level output registered; the raw path
  // inside the channel stays unsynchronised to the compare itself
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      compare_output_pin_one <= 1'b0;
      compare_output_pin_two <= 1'b0;
    end
    else
    begin
      compare_output_pin_one <= raw_one;
      compare_output_pin_two <= raw_two;
    end
  end

  // interrupt requests, level while the flag stands
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_one <= 1'b0;
      irq_two <= 1'b0;
    end
    else
    begin
      irq_one <= flag_one & irq_enable_reg1_q[`BIT_IRQ_EN_ONE]
                 & irq_enable_reg0_q[`BIT_GLOBAL_IRQ];
      irq_two <= flag_two & irq_enable_reg1_q[`BIT_IRQ_EN_TWO]
                 & irq_enable_reg0_q[`BIT_GLOBAL_IRQ];
    end
  end

  // ------------------------------------------------------------
  // warm-up tracking, informs software of the settle window
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_one_q <= CH_OFF;
      settle_one_q <= '0;
    end
    else
    begin
      case (st_one_q)
        CH_OFF:
        begin
          settle_one_q <= SETTLE;
          if (cfg_one.enable)
            st_one_q <= CH_ON;
        end
        CH_ON:
        begin
          if (!cfg_one.enable)
            st_one_q <= CH_OFF;
          else if (settle_one_q != 14'h0000)
            settle_one_q <= settle_one_q - 14'h0001;
        end
        default: st_one_q <= CH_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_two_q <= CH_OFF;
      settle_two_q <= '0;
    end
    else
    begin
      case (st_two_q)
        CH_OFF:
        begin
          settle_two_q <= SETTLE;
          if (cfg_two.enable)
            st_two_q <= CH_ON;
        end
        CH_ON:
        begin
          if (!cfg_two.enable)
            st_two_q <= CH_OFF;
          else if (settle_two_q != 14'h0000)
            settle_two_q <= settle_two_q - 14'h0001;
        end
        default: st_two_q <= CH_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      settling_one <= 1'b0;
      settling_two <= 1'b0;
    end
    else
    begin
      settling_one <= cfg_one.enable && settle_one_q != 14'h0000;
      settling_two <= cfg_two.enable && settle_two_q != 14'h0000;
    end
  end

  // ------------------------------------------------------------
  // port 0 input synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
    end
    else
    begin
      p0_s1_q <= port0_pins;
      p0_s2_q <= p0_s1_q;
    end
  end

  // ------------------------------------------------------------
  // read mux, data stands the cycle after the strobe only
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_d = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        `CMP_ONE_ADDR: rdata_d = comparator_one_control_q
                                 | {6'h00, res_one, flag_one};
        `CMP_TWO_ADDR: rdata_d = comparator_two_control_q
                                 | {6'h00, res_two, flag_two};
        `IRQ_EN0_ADDR: rdata_d = irq_enable_reg0_q;
        `IRQ_EN1_ADDR: rdata_d = irq_enable_reg1_q;
        `P0_DIS_ADDR: rdata_d = port0_digital_input_disable_q;
        // disabled inputs read zero
        `P0_READ_ADDR: rdata_d = p0_s2_q
                                 & ~port0_digital_input_disable_q;
        default: rdata_d = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rdata <= 8'h00;
    else
      rdata <= rdata_d;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_flag_set;
    flag_one && !$past(flag_one);
  endsequence

  a_irq_gate_one: assert property (
    @(posedge ref_clk) disable iff (reset)
    irq_one |-> $past(flag_one) && $past(irq_enable_reg0_q[7]))
    else $error("irq one without flag or global enable");

  a_irq_rise_one: assert property (
    @(posedge ref_clk) disable iff (reset)
    (flag_one && irq_enable_reg1_q[5] && irq_enable_reg0_q[7]) |=> irq_one)
    else $error("irq one missing");

  a_sync_off_one: assert property (
    @(posedge ref_clk) disable iff (reset)
    !cfg_one.enable |=> !res_one)
    else $error("synced result not zero while disabled");

  a_flag_on_change: assert property (
    @(posedge ref_clk) disable iff (reset)
    (cfg_one.enable && $past(cfg_one.enable) && $changed(res_one))
      |=> flag_one || !cfg_one.enable)
    else $error("change flag not set");

  a_flag_disable_clr: assert property (
    @(posedge ref_clk) disable iff (reset)
    !cfg_two.enable |=> !flag_two)
    else $error("flag two held while disabled");

  a_flag_cause: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_flag_set |-> $past(res_one) != $past(res_one, 2))
    else $error("flag set without a result change");

  a_pin_gate_two: assert property (
    @(posedge ref_clk) disable iff (reset)
    compare_output_pin_two |-> $past(cfg_two.enable && cfg_two.out_en))
    else $error("pin two driven while gated off");

  a_port_read_zero: assert property (
    @(posedge ref_clk) disable iff (reset)
    (req.rd && req.addr == `P0_READ_ADDR)
      |=> (rdata & $past(port0_digital_input_disable_q)) == 8'h00)
    else $error("disabled port bit read as one");

  a_read_one_cycle: assert property (
    @(posedge ref_clk) disable iff (reset)
    (req.rd && req.addr == `CMP_TWO_ADDR)
      |=> rdata[5:2] == $past(comparator_two_control_q[5:2]))
    else $error("control two readback wrong");
endmodule

// *** inc/cmp_params.svh ***
// constants for the dual comparator control block
// assumes byte-wide register port addressed at the cpu special register space
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH

// register addresses (8-bit)
`define CMP_ONE_ADDR 8'hAC
`define CMP_TWO_ADDR 8'hAD
`define IRQ_EN0_ADDR 8'hA8
`define IRQ_EN1_ADDR 8'hE8
`define P0_DIS_ADDR 8'hF6
`define P0_READ_ADDR 8'h80

// control register field positions
`define BIT_ENABLE 5
`define BIT_POS_SEL 4
`define BIT_NEG_SEL 3
`define BIT_OUT_EN 2
`define BIT_SYNC_RES 1
`define BIT_CHANGE 0

// interrupt enable bit positions
`define BIT_GLOBAL_IRQ 7
`define BIT_IRQ_EN_ONE 5
`define BIT_IRQ_EN_TWO 2

// reset value of every register
`define REG_RESET 8'h00

// writable mask of a control register (bits 7:6 reserved, bit 1 read only)
`define CTRL_WMASK 8'h3D

// settle time after enable, in ns, and cycles at 100 MHz
`define CLK_PERIOD_NS 10
`define SETTLE_NS 10000
`define SETTLE_CYCLES (`SETTLE_NS / `CLK_PERIOD_NS)

`endif

// *** inc/cmp_pkg.sv ***
// types shared by the comparator control block
// assumes cmp_params.svh is available on the include path
package cmp_pkg;

  // register port request from the cpu
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // settings one comparator channel takes from its control register
  typedef struct packed
  {
    logic enable;
    logic pos_sel;
    logic neg_sel;
    logic out_en;
  } chan_cfg_s;

  // warm-up tracking state of a channel
  typedef enum logic [0:0]
  {
    CH_OFF = 1'b0,
    CH_ON = 1'b1
  } chan_state_e;

endpackage

// *** rtl/cmp_sync2.sv ***
// two flip-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to ref_clk
`timescale 1ns/1ps
module cmp_sync2
  import cmp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // data
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q; // first stage, read only by the second

  // ------------------------------------------------------------
  // two stage capture
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** rtl/cmp_channel.sv ***
// one comparator channel: input routing, result sync and change flag
// assumes the analog compare is done outside and arrives as a level
`timescale 1ns/1ps
`include "cmp_params.svh"
module cmp_channel
  import cmp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // configuration and software clear
  input wire chan_cfg_s cfg,
  input wire logic flag_clr,
  // analog comparisons for each input pairing, asynchronous
  input wire logic [3:0] raw_cmp,
  // results
  output logic raw_out,
  output logic sync_res,
  output logic change_flag
);

  logic raw_sel; // selected raw result
  logic sync_w; // synchroniser output
  logic prev_q; // last synced result

  // raw_cmp index: {neg_sel, pos_sel}; each is pos > neg for that pair
  assign raw_sel =
    raw_cmp[{cfg.neg_sel, cfg.pos_sel}];
  // raw path leaves unsynchronised, gated by enable and output enable
  assign raw_out = cfg.enable & cfg.out_en & raw_sel;

  cmp_sync2 u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(raw_sel),
    .sync_out(sync_w)
  );

  // ------------------------------------------------------------
  // synced result and change detection
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sync_res <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      // forced low while disabled
      sync_res <= cfg.enable & sync_w;
      prev_q <= sync_res;
    end
  end

  // set wins over software clear; disable clears unconditionally
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      change_flag <= 1'b0;
    else if (!cfg.enable)
      change_flag <= 1'b0;
    else if (sync_res != prev_q)
      change_flag <= 1'b1;
    else if (flag_clr)
      change_flag <= 1'b0;
  end

endmodule

// *** sim/cmp_analog_model.sv ***
// behavioural model of the analog side of one comparator channel
// assumes pin voltages come from the bench as millivolt integers
`timescale 1ns/1ps
module cmp_analog_model
#(
  // internal reference level in millivolts
  parameter logic [11:0] VREF_MV = 12'h500
)
(
  // pin voltages in millivolts
  input wire logic [11:0] pin_a_mv,
  input wire logic [11:0] pin_b_mv,
  input wire logic [11:0] ref_mv,
  // comparisons, index {neg_sel, pos_sel}
  output logic [3:0] raw
);
  // ---------------------------------------------------------------
  // comparisons for all four pairings
  // ---------------------------------------------------------------
  // strict greater-than: equal voltages read as zero, like the silicon
  always_comb
  begin
    raw[0] = pin_a_mv > ref_mv;
    raw[1] = pin_b_mv > ref_mv;
    raw[2] = pin_a_mv > VREF_MV;
    raw[3] = pin_b_mv > VREF_MV;
  end
endmodule

// *** sim/cmp_control_tb.sv ***
// self-checking bench for the dual comparator control block
// assumes fixed latencies: result about 3 cycles, flag +1, irq +1
`timescale 1ns/1ps
`include "cmp_params.svh"
module cmp_control_tb
  import cmp_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;  // 100 MHz clock
  logic reset = 1'b1;  // held for 8 cycles
  reg_req_s req = '0;  // register port request
  logic [7:0] rdata;
  logic [3:0] raw1, raw2;  // pairings from the analog models
  logic [7:0] port0_pins = 8'h00;
  logic pin1, pin2, irq1, irq2;
  logic set1, set2;  // warm-up status of each channel
  logic [11:0] pa1 = 12'h000, pb1 = 12'h000;  // channel one pins, mV
  logic [11:0] pa2 = 12'h000, pb2 = 12'h000;  // channel two pins, mV
  logic [11:0] refv = 12'h320;  // shared reference pin, mV
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  // ---------------------------------------------------------------
  // clock, design and far side
  // ---------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;

  cmp_control dut (.ref_clk(ref_clk), .reset(reset), .req(req),
    .rdata(rdata), .cmp_one_raw(raw1), .cmp_two_raw(raw2),
    .port0_pins(port0_pins), .compare_output_pin_one(pin1),
    .compare_output_pin_two(pin2), .irq_one(irq1), .irq_two(irq2),
    .settling_one(set1), .settling_two(set2));
  cmp_analog_model an1 (.pin_a_mv(pa1), .pin_b_mv(pb1), .ref_mv(refv),
    .raw(raw1));
  cmp_analog_model an2 (.pin_a_mv(pa2), .pin_b_mv(pb2), .ref_mv(refv),
    .raw(raw2));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // cycle ceiling well above the 1200 or so cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one-cycle write strobe, released at the next edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // reset values, reserved bits, unmapped place
  task automatic t_reset_map();
    logic [7:0] d;
    rd_reg(`CMP_ONE_ADDR, d);
    chk8(d, 8'h00);
    rd_reg(`CMP_TWO_ADDR, d);
    chk8(d, 8'h00);
    wr_reg(`CMP_ONE_ADDR, 8'hC2);
    rd_reg(`CMP_ONE_ADDR, d);
    chk8(d, 8'h00);
    wr_reg(8'h10, 8'hFF);
    rd_reg(8'h10, d);
    chk8(d, 8'h00);
  endtask

  // enable channel one on pin a against the reference pin, output on
  task automatic t_enable_one();
    logic [7:0] d;
    wr_reg(`P0_DIS_ADDR, 8'h30);
    pa1 <= 12'h3E8;
    wr_reg(`CMP_ONE_ADDR, 8'h24);
    wait_clk(6);
    chk1(pin1, 1'b1);
    chk1(set1, 1'b1);
    rd_reg(`CMP_ONE_ADDR, d);
    chk8(d, 8'h27);
    // the result was read during warm-up; now wait out the rest and see settling fall
    wait_clk(`SETTLE_CYCLES - 8);
    chk1(set1, 1'b1);
    wait_clk(2);
    chk1(set1, 1'b0);
  endtask

  // all eight selections on channel two; results 1,1,0,1 by pairing
  task automatic t_eight_cfg();
    logic [7:0] d;
    logic [7:0] e;
    logic [11:0] p, n;
    logic res;
    @(posedge ref_clk);
    pa2 <= 12'h3E8;
    pb2 <= 12'h5DC;
    for (int c = 0; c < 8; c++)
    begin
      // bit 5 enable, bits 4:2 the selection under test
      wr_reg(`CMP_TWO_ADDR, {2'h0, 1'b1, c[2:0], 2'h0});
      p = c[2] ? pb2 : pa2;
      n = c[1] ? 12'h500 : refv;
      res = p > n;
      e = {2'h0, 1'b1, c[2:0], res, 1'b0};
      wait_clk(6);
      rd_reg(`CMP_TWO_ADDR, d);
      chk8(d & 8'hFE, e);
      chk1(pin2, c[0] & res);
    end
    // pin b drops under the internal level: result falls, flag rises
    @(posedge ref_clk);
    pb2 <= 12'h100;
    wait_clk(8);
    chk1(set2, 1'b1);
    rd_reg(`CMP_TWO_ADDR, d);
    chk8(d, 8'h3D);
  endtask

  // flag clear, interrupt gating and disable
  task automatic t_flag_irq();
    logic [7:0] d;
    wr_reg(`CMP_ONE_ADDR, 8'h24);
    rd_reg(`CMP_ONE_ADDR, d);
    chk8(d, 8'h26);
    wr_reg(`IRQ_EN0_ADDR, 8'h80);
    wr_reg(`IRQ_EN1_ADDR, 8'h20);
    wait_clk(3);
    chk1(irq1, 1'b0);
    @(posedge ref_clk);
    pa1 <= 12'h064;
    wait_clk(8);
    chk1(irq1, 1'b1);
    chk1(pin1, 1'b0);
    chk1(irq2, 1'b0);
    rd_reg(`CMP_ONE_ADDR, d);
    chk8(d, 8'h25);
    wr_reg(`IRQ_EN0_ADDR, 8'h00);
    wait_clk(3);
    chk1(irq1, 1'b0);
    wr_reg(`IRQ_EN0_ADDR, 8'h80);
    wait_clk(3);
    chk1(irq1, 1'b1);
    wr_reg(`CMP_ONE_ADDR, 8'h04);
    wait_clk(3);
    chk1(irq1, 1'b0);
    rd_reg(`CMP_ONE_ADDR, d);
    chk8(d, 8'h04);
  endtask

  // port 0 pins with digital input disabled read as zero
  task automatic t_port0();
    logic [7:0] d;
    wr_reg(`P0_DIS_ADDR, 8'h30);
    port0_pins <= 8'hFF;
    wait_clk(4);
    rd_reg(`P0_READ_ADDR, d);
    chk8(d, 8'hCF);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_map();
    t_enable_one();
    t_eight_cfg();
    t_flag_irq();
    t_port0();
    complete_run();
  end
endmodule
